// *** hdl/bsr_pkg.sv ***
// Constants for the boundary-scan instruction and data register block
package bsr_pkg;
	// ---------------------------------------------------------------
	// Instruction register
	// ---------------------------------------------------------------
	localparam int          IR_LEN          = 6;
	localparam logic [5:0]  OP_EXTEST       = 6'h00;
	localparam logic [5:0]  OP_SAMPLE       = 6'h01;
	localparam logic [5:0]  OP_IDCODE       = 6'h02;
	localparam logic [5:0]  OP_HIGHZ        = 6'h03;
	localparam logic [5:0]  OP_CAPTURE_PAT  = 6'h2d;
	localparam logic [5:0]  OP_AC_TRAIN     = 6'h3c;
	localparam logic [5:0]  OP_AC_PULSE     = 6'h3d;
	localparam logic [5:0]  OP_CLAMP        = 6'h3e;
	localparam logic [5:0]  OP_BYPASS       = 6'h3f;
	// ---------------------------------------------------------------
	// Identification register and controller reset count
	// ---------------------------------------------------------------
	localparam int          ID_LEN          = 32;
	localparam int          TLR_TMS_COUNT   = 5;
	// ---------------------------------------------------------------
	// Controller states
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_RESET   = 4'h0, ST_IDLE    = 4'h1, ST_SEL_DR  = 4'h2, ST_CAP_DR  = 4'h3,
		ST_SH_DR   = 4'h4, ST_EX1_DR  = 4'h5, ST_PAU_DR  = 4'h6, ST_EX2_DR  = 4'h7,
		ST_UPD_DR  = 4'h8, ST_SEL_IR  = 4'h9, ST_CAP_IR  = 4'ha, ST_SH_IR   = 4'hb,
		ST_EX1_IR  = 4'hc, ST_PAU_IR  = 4'hd, ST_EX2_IR  = 4'he, ST_UPD_IR  = 4'hf
	} bsr_state_e;
endpackage : bsr_pkg

// *** hdl/bsr_cell.sv ***
// One boundary-scan cell: shift stage plus falling-edge update latch
`timescale 1ns/1ns
module bsr_cell (
	// Clock and reset
	input  wire logic clock_in,
	input  wire logic rst_n_in,
	// Test clock edges found by the top
	input  wire logic rise_in,
	input  wire logic fall_in,
	// Control
	input  wire logic capture_in,
	input  wire logic shift_in,
	input  wire logic update_in,
	// Data
	input  wire logic par_in,
	input  wire logic ser_in,
	output logic      ser_out,
	output logic      latch_out
);
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ser_out <= 1'b0;
		end else if (rise_in && capture_in) begin
			ser_out <= par_in;
		end else if (rise_in && shift_in) begin
			ser_out <= ser_in;
		end
	end

	// Update on the falling test clock so skew cannot corrupt the value
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			latch_out <= 1'b0;
		end else if (fall_in && update_in) begin
			latch_out <= ser_out;
		end
	end
endmodule : bsr_cell

// *** hdl/bsr_top.sv ***
// Boundary-scan controller, instruction register and test data registers
`timescale 1ns/1ns
// Summary of operation
// - Bypass, boundary and ID registers sit in parallel on one serial path.
// - Boundary chain is selected under external test, sample/preload or AC training/pulse test.
// - External test drives boundary latches onto pins once it becomes current.
// - Each boundary cell updates its latch on the falling test clock.
// - Input cells only observe the pin, never drive toward the core.
// - Bidirectional pin uses an enable cell plus a muxed capture cell.
// - Capture takes core output data when enable high and not external test or AC training/pulse test.
// - Capture takes pad input when enable low or external test active.
// - Instruction bits shift in on rising test clock in instruction shift.
// - Shifted instruction becomes current only at instruction update.
// - Six-bit instruction selects the active data register and path.
// - Unselected data registers never disturb the chip or selected register.
// - 000000 is external test, 000001 is sample/preload, both boundary.
// - 000010 selects the identification register.
// - 000011 tri-states all output and bidirectional cells.
// - Instruction capture loads 101101, low bits 01.
// - 111100 is AC training test, 111101 is AC pulse test.
// - 111110 clamps pins from latches while scanning through bypass.
// - 111111 is one-bit bypass; other opcodes are reserved.
// - External test shifts chain and applies it to pins at data update.
// - Sample/preload captures all pin states and enables into chain.
// - Bypass bit loads zero at data capture.
// - Controller reset makes identification the current instruction.
// - Identification value is 32 bits with least significant bit one.
module bsr_top import bsr_pkg::*; #(
	parameter int         N_IN      = 4,
	parameter int         N_OUT     = 4,
	parameter int         N_BIDIR   = 4,
	parameter logic [3:0] ID_VER    = 4'h0,
	parameter logic [10:0] ID_MAKER = 11'h2aa, // Arbitrary value
	parameter logic [15:0] ID_PART  = 16'h1234 // Arbitrary value
) (
	// Clock and reset
	input  wire logic               clock_in,
	input  wire logic               rst_n_in,
	// Test access pins
	input  wire logic               tck_in,
	input  wire logic               tms_in,
	input  wire logic               tdi_in,
	input  wire logic               trst_n_in,
	output logic                    tdo_out,
	output logic                    tdo_oe_out,
	// Input pins
	input  wire logic [N_IN-1:0]    in_pad_in,
	output logic [N_IN-1:0]         in_core_out,
	// Output pins
	input  wire logic [N_OUT-1:0]   out_core_in,
	input  wire logic [N_OUT-1:0]   out_core_oe_in,
	output logic [N_OUT-1:0]        out_pad_out,
	output logic [N_OUT-1:0]        out_pad_oe_out,
	// Bidirectional pins
	input  wire logic [N_BIDIR-1:0] bi_core_in,
	input  wire logic [N_BIDIR-1:0] bi_core_oe_in,
	input  wire logic [N_BIDIR-1:0] bi_pad_in,
	output logic [N_BIDIR-1:0]      bi_pad_out,
	output logic [N_BIDIR-1:0]      bi_pad_oe_out,
	output logic [N_BIDIR-1:0]      bi_core_out,
	// Status
	output logic [IR_LEN-1:0]       instr_out,
	output logic                    ac_mode_out
);
	// ---------------------------------------------------------------
	// Pin synchronisers and test clock edges
	// ---------------------------------------------------------------
	localparam int CHAIN = N_IN + 2*N_OUT + 2*N_BIDIR;
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic       tck_d_r;
	logic       rise;
	logic       fall;
	logic       tms_s;
	logic       tdi_s;
	logic       trst_s;
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync1_r <= 4'h8;
			sync2_r <= 4'h8;
			tck_d_r <= 1'b0;
		end else begin
			sync1_r <= {trst_n_in, tdi_in, tms_in, tck_in};
			sync2_r <= sync1_r;
			tck_d_r <= sync2_r[0];
		end
	end
	assign rise   = sync2_r[0] & ~tck_d_r;
	assign fall   = ~sync2_r[0] & tck_d_r;
	assign tms_s  = sync2_r[1];
	assign tdi_s  = sync2_r[2];
	assign trst_s = ~sync2_r[3];
	// ---------------------------------------------------------------
	// Controller
	// ---------------------------------------------------------------
	bsr_state_e st_r;
	bsr_state_e st_nxt;
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			ST_RESET:  st_nxt = tms_s ? ST_RESET  : ST_IDLE;
			ST_IDLE:   st_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: st_nxt = tms_s ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: st_nxt = tms_s ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR:  st_nxt = tms_s ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: st_nxt = tms_s ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: st_nxt = tms_s ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: st_nxt = tms_s ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: st_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: st_nxt = tms_s ? ST_RESET  : ST_CAP_IR;
			ST_CAP_IR: st_nxt = tms_s ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR:  st_nxt = tms_s ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: st_nxt = tms_s ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: st_nxt = tms_s ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: st_nxt = tms_s ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: st_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
		endcase
	end
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r <= ST_RESET;
		end else if (trst_s) begin
			st_r <= ST_RESET;
		end else if (rise) begin
			st_r <= st_nxt;
		end
	end
	// ---------------------------------------------------------------
	// Instruction register
	// ---------------------------------------------------------------
	logic [IR_LEN-1:0] ir_sh_r;
	logic [IR_LEN-1:0] ir_r;
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ir_sh_r <= OP_CAPTURE_PAT;
		end else if (rise && st_r == ST_CAP_IR) begin
			ir_sh_r <= OP_CAPTURE_PAT;
		end else if (rise && st_r == ST_SH_IR) begin
			ir_sh_r <= {tdi_s, ir_sh_r[IR_LEN-1:1]};
		end
	end
	// Current instruction changes on the falling edge in instruction update
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ir_r <= OP_IDCODE;
		end else if (trst_s || st_r == ST_RESET) begin
			ir_r <= OP_IDCODE;
		end else if (fall && st_r == ST_UPD_IR) begin
			ir_r <= ir_sh_r;
		end
	end
	// ---------------------------------------------------------------
	// Instruction decode
	// ---------------------------------------------------------------
	// Reserved opcodes fall back to bypass so nothing is disturbed
	function automatic logic [1:0] dr_sel(input logic [IR_LEN-1:0] op);
		unique case (op)
			OP_EXTEST, OP_SAMPLE, OP_AC_TRAIN, OP_AC_PULSE: dr_sel = 2'h1;
			OP_IDCODE: dr_sel = 2'h2;
			default:   dr_sel = 2'h0;
		endcase
	endfunction : dr_sel
	logic [1:0] sel;
	logic       ext_mode;
	logic       highz;
	assign sel      = dr_sel(ir_r);
	assign ext_mode = (ir_r == OP_EXTEST) || (ir_r == OP_CLAMP) ||
	                  (ir_r == OP_AC_TRAIN) || (ir_r == OP_AC_PULSE);
	assign highz    = (ir_r == OP_HIGHZ);
	// ---------------------------------------------------------------
	// Bypass and identification
	// ---------------------------------------------------------------
	logic              byp_r;
	logic [ID_LEN-1:0] id_r;
	logic              cap_dr;
	logic              sh_dr;
	assign cap_dr = (st_r == ST_CAP_DR);
	assign sh_dr  = (st_r == ST_SH_DR);
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			byp_r <= 1'b0;
		end else if (rise && cap_dr && sel == 2'h0) begin
			byp_r <= 1'b0;
		end else if (rise && sh_dr && sel == 2'h0) begin
			byp_r <= tdi_s;
		end
	end
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			id_r <= '0;
		end else if (rise && cap_dr && sel == 2'h2) begin
			id_r <= {ID_VER, ID_PART, ID_MAKER, 1'b1};
		end else if (rise && sh_dr && sel == 2'h2) begin
			id_r <= {tdi_s, id_r[ID_LEN-1:1]};
		end
	end
	// ---------------------------------------------------------------
	// Boundary chain
	// ---------------------------------------------------------------
	// Order from TDI: bidir enable/capture, output enable/data, inputs
	logic [CHAIN-1:0] par;
	logic [CHAIN:0]   ser;
	logic [CHAIN-1:0] lat;
	logic             bs_cap;
	logic             bs_sh;
	logic             bs_upd;
	assign bs_cap = cap_dr && sel == 2'h1;
	assign bs_sh  = sh_dr && sel == 2'h1;
	assign bs_upd = (st_r == ST_UPD_DR) && sel == 2'h1;
	assign ser[CHAIN] = tdi_s;
	genvar g;
	generate
		for (g = 0; g < N_IN; g++) begin : g_in
			assign par[g] = in_pad_in[g];
		end
		for (g = 0; g < N_OUT; g++) begin : g_out
			assign par[N_IN+2*g]   = out_core_in[g];
			assign par[N_IN+2*g+1] = out_core_oe_in[g];
		end
		for (g = 0; g < N_BIDIR; g++) begin : g_bi
			localparam int B = N_IN + 2*N_OUT + 2*g;
			// Enable cell steers capture between core data and pad
			assign par[B]   = (bi_core_oe_in[g] && !ext_mode) ? bi_core_in[g]
			                                                   : bi_pad_in[g];
			assign par[B+1] = bi_core_oe_in[g];
		end
		for (g = 0; g < CHAIN; g++) begin : g_cell
			bsr_cell i_bsr_cell (
				.clock_in   (clock_in),
				.rst_n_in   (rst_n_in),
				.rise_in    (rise),
				.fall_in    (fall),
				.capture_in (bs_cap),
				.shift_in   (bs_sh),
				.update_in  (bs_upd),
				.par_in     (par[g]),
				.ser_in     (ser[g+1]),
				.ser_out    (ser[g]),
				.latch_out  (lat[g])
			);
		end
	endgenerate
	// ---------------------------------------------------------------
	// Pin drive, registered at the boundary
	// ---------------------------------------------------------------
	logic [N_OUT-1:0]   lo_d;
	logic [N_OUT-1:0]   lo_e;
	logic [N_BIDIR-1:0] lb_d;
	logic [N_BIDIR-1:0] lb_e;
	generate
		for (g = 0; g < N_OUT; g++) begin : g_lo
			assign lo_d[g] = lat[N_IN+2*g];
			assign lo_e[g] = lat[N_IN+2*g+1];
		end
		for (g = 0; g < N_BIDIR; g++) begin : g_lb
			assign lb_d[g] = lat[N_IN+2*N_OUT+2*g];
			assign lb_e[g] = lat[N_IN+2*N_OUT+2*g+1];
		end
	endgenerate
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			out_pad_out    <= '0;
			out_pad_oe_out <= '0;
			bi_pad_out     <= '0;
			bi_pad_oe_out  <= '0;
		end else if (highz) begin
			out_pad_out    <= out_core_in;
			out_pad_oe_out <= '0;
			bi_pad_out     <= bi_core_in;
			bi_pad_oe_out  <= '0;
		end else if (ext_mode) begin
			out_pad_out    <= lo_d;
			out_pad_oe_out <= lo_e;
			bi_pad_out     <= lb_d;
			bi_pad_oe_out  <= lb_e;
		end else begin
			out_pad_out    <= out_core_in;
			out_pad_oe_out <= out_core_oe_in;
			bi_pad_out     <= bi_core_in;
			bi_pad_oe_out  <= bi_core_oe_in;
		end
	end
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			in_core_out <= '0;
			bi_core_out <= '0;
			instr_out   <= OP_IDCODE;
			ac_mode_out <= 1'b0;
		end else begin
			in_core_out <= in_pad_in;
			bi_core_out <= bi_pad_in;
			instr_out   <= ir_r;
			ac_mode_out <= (ir_r == OP_AC_TRAIN || ir_r == OP_AC_PULSE) && st_r == ST_IDLE;
		end
	end
	// ---------------------------------------------------------------
	// Serial output, changed on the falling test clock
	// ---------------------------------------------------------------
	logic tdo_src;
	always_comb begin
		tdo_src = byp_r;
		if (st_r == ST_SH_IR) begin
			tdo_src = ir_sh_r[0];
		end else if (sel == 2'h1) begin
			tdo_src = ser[0];
		end else if (sel == 2'h2) begin
			tdo_src = id_r[0];
		end
	end
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tdo_out    <= 1'b0;
			tdo_oe_out <= 1'b0;
		end else if (fall) begin
			tdo_out    <= tdo_src;
			tdo_oe_out <= (st_r == ST_SH_IR) || sh_dr;
		end
	end
	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	logic [2:0] tms_cnt_r;
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tms_cnt_r <= '0;
		end else if (rise) begin
			tms_cnt_r <= !tms_s ? 3'h0 : (tms_cnt_r == 3'h7 ? 3'h7 : tms_cnt_r + 3'h1);
		end
	end
	tms_reset_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		tms_cnt_r >= 3'(TLR_TMS_COUNT) |-> st_r == ST_RESET ##1 ir_r == OP_IDCODE)
		else $error("Controller not reset after held mode select");
	ir_capture_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		rise && st_r == ST_CAP_IR && !trst_s |=> ir_sh_r == OP_CAPTURE_PAT)
		else $error("Capture pattern not loaded");
	ir_update_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		!(fall && st_r == ST_UPD_IR) && !trst_s && st_r != ST_RESET |=> $stable(ir_r))
		else $error("Instruction changed outside update");
	ir_shift_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		rise && st_r == ST_SH_IR |=> ir_sh_r[IR_LEN-1] == $past(tdi_s))
		else $error("Instruction shift lost input bit");
	bypass_zero_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		rise && cap_dr && sel == 2'h0 |=> !byp_r)
		else $error("Bypass bit not cleared at capture");
	id_lsb_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		rise && cap_dr && sel == 2'h2 |=> id_r[0])
		else $error("Identification low bit not one");
	highz_drive_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		highz && $past(highz) |-> out_pad_oe_out == '0 && bi_pad_oe_out == '0)
		else $error("Outputs enabled under high impedance");
	ext_drive_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		ext_mode && !highz |=> out_pad_out == $past(lo_d) && out_pad_oe_out == $past(lo_e))
		else $error("Latches not driven to pins in external test");
	tdo_fall_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		!fall |=> $stable(tdo_out))
		else $error("Serial output changed off falling edge");
	clamp_path_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		ir_r == OP_CLAMP |-> sel == 2'h0 && ext_mode)
		else $error("Clamp decode wrong");
	cv_ir_update_c: cover property (@(posedge clock_in) disable iff (!rst_n_in)
		fall && st_r == ST_UPD_IR);
	cv_extest_c: cover property (@(posedge clock_in) disable iff (!rst_n_in)
		ir_r == OP_EXTEST && bs_upd && fall);
	cv_id_shift_c: cover property (@(posedge clock_in) disable iff (!rst_n_in)
		sel == 2'h2 && sh_dr && rise);
	cv_sample_c: cover property (@(posedge clock_in) disable iff (!rst_n_in)
		ir_r == OP_SAMPLE && bs_cap && rise);
endmodule : bsr_top

// *** bench/bsr_tester.sv ***
// Tester model that drives the serial test access pins
`timescale 1ns/1ns
module bsr_tester (
	// Clock
	input  wire logic clock_in,
	// Test access pins
	input  wire logic tdo_in,
	input  wire logic tdo_oe_in,
	output logic      tck_out,
	output logic      tms_out,
	output logic      tdi_out,
	output logic      trst_n_out
);
	// Mode select and data rest high, as pull-ups would leave them
	initial begin
		tck_out    = 1'b0;
		tms_out    = 1'b1;
		tdi_out    = 1'b1;
		trst_n_out = 1'b0;
	end

	// --------------------------------------------------------------
	// One test clock bit
	// --------------------------------------------------------------
	// Clock stands low between bits; the serial output is read late in the high phase
	task automatic bit_cycle(input logic t, input logic d, output logic q);
		@(negedge clock_in);
		tms_out = t;
		tdi_out = d;
		repeat (3) @(negedge clock_in);
		tck_out = 1'b1;
		repeat (4) @(negedge clock_in);
		// A released output reads inverted, so a missing enable shows up
		q       = tdo_oe_in ? tdo_in : ~tdo_in;
		tck_out = 1'b0;
	endtask : bit_cycle

	// --------------------------------------------------------------
	// Controller reset by pin or by five mode-select ones, then Idle
	// --------------------------------------------------------------
	task automatic tap_reset(input logic use_pin);
		logic q;
		if (use_pin) begin
			@(negedge clock_in);
			trst_n_out = 1'b0;
			repeat (4) @(negedge clock_in);
			trst_n_out = 1'b1;
			repeat (4) @(negedge clock_in);
		end else begin
			repeat (5) bit_cycle(1'b1, 1'b1, q);
		end
		bit_cycle(1'b0, 1'b1, q);
	endtask : tap_reset

	// --------------------------------------------------------------
	// One scan from Idle back to Idle, least significant bit first
	// --------------------------------------------------------------
	task automatic scan(input logic is_ir, input int n, input logic [63:0] din,
		output logic [63:0] dout);
		logic q;
		dout = '0;
		bit_cycle(1'b1, 1'b1, q);
		if (is_ir) bit_cycle(1'b1, 1'b1, q);
		bit_cycle(1'b0, 1'b1, q);
		bit_cycle(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++) begin
			bit_cycle(i == n - 1, din[i], q);
			dout[i] = q;
		end
		bit_cycle(1'b1, 1'b1, q);
		bit_cycle(1'b0, 1'b1, q);
	endtask : scan
endmodule : bsr_tester

// *** bench/tb_top.sv ***
// Self-checking bench for the boundary-scan block
`timescale 1ns/1ns
module tb_top import bsr_pkg::*; ;
	localparam int          CH      = 20;
	localparam logic [3:0]  T_VER   = 4'h5;
	localparam logic [10:0] T_MAKER = 11'h155; // Arbitrary value
	localparam logic [15:0] T_PART  = 16'h0f0f; // Arbitrary value
	logic        clock_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        tck, tms, tdi, trst_n, tdo, tdo_oe, ac_mode;
	logic [3:0]  in_pad = 4'h0, out_core = 4'h0, out_core_oe = 4'h0;
	logic [3:0]  bi_core = 4'h0, bi_core_oe = 4'h0, bi_pad = 4'h0;
	logic [3:0]  in_core, out_pad, out_pad_oe, bi_pad_out, bi_pad_oe, bi_core_out;
	logic [5:0]  instr;
	logic [63:0] dout;
	int          fails = 0;
	int          checks = 0;

	always #20 clock_in = ~clock_in;

	bsr_top #(.ID_VER(T_VER), .ID_MAKER(T_MAKER), .ID_PART(T_PART)) i_bsr_top (
		.clock_in(clock_in), .rst_n_in(rst_n_in), .tck_in(tck), .tms_in(tms),
		.tdi_in(tdi), .trst_n_in(trst_n), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
		.in_pad_in(in_pad), .in_core_out(in_core), .out_core_in(out_core),
		.out_core_oe_in(out_core_oe), .out_pad_out(out_pad), .out_pad_oe_out(out_pad_oe),
		.bi_core_in(bi_core), .bi_core_oe_in(bi_core_oe), .bi_pad_in(bi_pad),
		.bi_pad_out(bi_pad_out), .bi_pad_oe_out(bi_pad_oe), .bi_core_out(bi_core_out),
		.instr_out(instr), .ac_mode_out(ac_mode));

	bsr_tester i_bsr_tester (.clock_in(clock_in), .tdo_in(tdo), .tdo_oe_in(tdo_oe), .tck_out(tck),
		.tms_out(tms), .tdi_out(tdi), .trst_n_out(trst_n));

	// --------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic test_done;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : test_done

	// Pins settle one clock after the instruction changes, so wait a few
	task automatic load_ir(input logic [5:0] op);
		i_bsr_tester.scan(1'b1, IR_LEN, {58'h0, op}, dout);
		repeat (4) @(negedge clock_in);
	endtask : load_ir

	task automatic scan_dr(input int n, input logic [63:0] din);
		i_bsr_tester.scan(1'b0, n, din, dout);
		repeat (4) @(negedge clock_in);
	endtask : scan_dr

	// Pin drive expected from a chain image: {bidir oe, bidir data, out oe, out data}
	function automatic logic [15:0] pins_of(input logic [63:0] v);
		logic [15:0] r;
		for (int i = 0; i < 4; i++) begin
			r[i]    = v[4+2*i];
			r[4+i]  = v[5+2*i];
			r[8+i]  = v[12+2*i];
			r[12+i] = v[13+2*i];
		end
		return r;
	endfunction : pins_of

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_reset_id;
		check(instr, OP_IDCODE, "instr after reset");
		check(tdo_oe, 1'b0, "tdo enable idle");
		scan_dr(ID_LEN, 64'h0);
		check(dout[31:0], {T_VER, T_PART, T_MAKER, 1'b1}, "id value");
		load_ir(OP_BYPASS);
		check(dout[5:0], OP_CAPTURE_PAT, "ir capture");
		check(instr, OP_BYPASS, "ir update");
	endtask : t_reset_id

	task automatic t_sample_extest;
		logic [63:0] e, p, q;
		in_pad      = 4'ha;
		out_core    = 4'h6;
		out_core_oe = 4'hc;
		bi_core     = 4'h3;
		bi_core_oe  = 4'h5;
		bi_pad      = 4'h9;
		p = 64'h5_c3a6;
		q = 64'hb_1e59;
		for (int i = 0; i < 4; i++) begin
			e[i]      = in_pad[i];
			e[4+2*i]  = out_core[i];
			e[5+2*i]  = out_core_oe[i];
			e[12+2*i] = bi_core_oe[i] ? bi_core[i] : bi_pad[i];
			e[13+2*i] = bi_core_oe[i];
		end
		load_ir(OP_SAMPLE);
		scan_dr(CH, p);
		check(dout[19:0], e[19:0], "sample capture");
		check({out_pad_oe, out_pad}, {out_core_oe, out_core}, "pins normal");
		check(in_core, in_pad, "input cell");
		check(bi_core_out, bi_pad, "bidir core copy");
		// Preloaded before external test, so the pins never see unknown data
		load_ir(OP_EXTEST);
		check({bi_pad_oe, bi_pad_out, out_pad_oe, out_pad}, pins_of(p), "extest");
		scan_dr(CH, q);
		for (int i = 0; i < 4; i++) check(dout[12+2*i], bi_pad[i], "bidir pad");
		check(dout[3:0], in_pad, "input sampled");
		check({bi_pad_oe, bi_pad_out, out_pad_oe, out_pad}, pins_of(q), "update");
		check(in_core, in_pad, "input cell");
		load_ir(OP_CLAMP);
		check({bi_pad_oe, bi_pad_out, out_pad_oe, out_pad}, pins_of(q), "clamp");
	endtask : t_sample_extest

	task automatic t_paths;
		logic [5:0]  ops [8] = '{OP_EXTEST, OP_SAMPLE, OP_IDCODE, OP_AC_TRAIN, OP_AC_PULSE,
			OP_CLAMP, OP_BYPASS, 6'h15};
		int          lens [8] = '{CH, CH, ID_LEN, CH, CH, 1, 1, 1};
		logic [63:0] din, m;
		din = 64'h0_0a5c_396e_10f5;
		for (int k = 0; k < 8; k++) begin
			load_ir(ops[k]);
			check(instr, ops[k], "opcode");
			check(ac_mode, (k == 3 || k == 4), "ac mode");
			scan_dr(44, din);
			m = (64'h1 << (44 - lens[k])) - 64'h1;
			check((dout >> lens[k]) & m, din & m, "path length");
			if (lens[k] == 1) check(dout[0], 1'b0, "bypass capture");
		end
		check({out_pad_oe, out_pad}, {out_core_oe, out_core}, "reserved");
	endtask : t_paths

	task automatic t_highz_resets;
		out_core_oe = 4'hf;
		bi_core_oe  = 4'hf;
		load_ir(OP_HIGHZ);
		check({out_pad_oe, bi_pad_oe}, 8'h00, "high impedance");
		load_ir(OP_BYPASS);
		check(out_pad_oe, 4'hf, "enables back");
		i_bsr_tester.tap_reset(1'b0);
		repeat (4) @(negedge clock_in);
		check(instr, OP_IDCODE, "mode select reset");
		load_ir(OP_BYPASS);
		i_bsr_tester.tap_reset(1'b1);
		repeat (4) @(negedge clock_in);
		check(instr, OP_IDCODE, "pin reset");
	endtask : t_highz_resets

	// --------------------------------------------------------------
	// Main sequence and watchdog
	// --------------------------------------------------------------
	initial begin
		repeat (16) @(negedge clock_in);
		rst_n_in = 1'b1;
		repeat (4) @(negedge clock_in);
		i_bsr_tester.tap_reset(1'b1);
		t_reset_id();
		t_sample_extest();
		t_paths();
		t_highz_resets();
		test_done();
	end

	// Whole run needs about 6k clocks; this allows about four times that
	initial begin
		#1000000;
		fails++;
		test_done();
	end
endmodule : tb_top
